// ---- src/sie_pkg.sv ----
package sie_pkg;

    // ****************************************
    // Bus geometry and responses
    // ****************************************
    localparam int          SIE_AW          = 8;
    localparam logic [1:0]  SIE_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SIE_RESP_SLVERR = 2'h2;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0]  SIE_OFF_EVT_EN   = 8'h00;
    localparam logic [7:0]  SIE_OFF_WM       = 8'h04;
    localparam logic [7:0]  SIE_OFF_STS      = 8'h08;
    localparam logic [7:0]  SIE_OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0]  SIE_OFF_BAUD     = 8'h10;
    localparam logic [7:0]  SIE_OFF_FLAGS    = 8'h14;
    localparam logic [7:0]  SIE_OFF_COUNTS   = 8'h18;

    // ****************************************
    // Event bit positions (enable layout)
    // ****************************************
    localparam int SIE_B_FRAME = 12;
    localparam int SIE_B_BUSY  = 11;
    localparam int SIE_B_UNDR  = 8;
    localparam int SIE_B_SHMT  = 7;
    localparam int SIE_B_OVF   = 6;
    localparam int SIE_B_RXE   = 5;
    localparam int SIE_B_TXE   = 3;
    localparam int SIE_B_TXF   = 1;
    localparam int SIE_B_RXF   = 0;
    localparam int SIE_B_RXWM  = 14;
    localparam int SIE_B_TXWM  = 15;
    localparam logic [15:0] SIE_EVT_IMPL = 16'h19EB;
    localparam logic [15:0] SIE_STS_IMPL = 16'hD9EB;

    // ****************************************
    // Watermark register fields
    // ****************************************
    localparam int SIE_FIFO_DEPTH = 32;
    localparam int SIE_B_RX_WATERMARK_ENABLE   = 15;
    localparam int SIE_B_TX_WATERMARK_ENABLE   = 7;
    localparam int SIE_RXLVL_LSB  = 8;
    localparam int SIE_TXLVL_LSB  = 0;
    localparam logic [5:0] SIE_LVL_IMPL = 6'h23
        | (SIE_FIFO_DEPTH >= 8  ? 6'h04 : 6'h00)
        | (SIE_FIFO_DEPTH >= 16 ? 6'h08 : 6'h00)
        | (SIE_FIFO_DEPTH == 32 ? 6'h10 : 6'h00);
    localparam logic [15:0] SIE_WM_IMPL =
        {2'h2, SIE_LVL_IMPL, 2'h2, SIE_LVL_IMPL};

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] SIE_RST_EVT_EN = 16'h0000;
    localparam logic [15:0] SIE_RST_WM     = 16'h0000;
    localparam logic [15:0] SIE_RST_MASK   = 16'h0000;
    localparam logic [15:0] SIE_RST_BAUD   = 16'h0000;

    // ****************************************
    // Bus channel states
    // ****************************************
    typedef enum logic [1:0] {
        SIE_WR_COLLECT = 2'h1,
        SIE_WR_RESP    = 2'h2
    } sie_wr_state_type;

    typedef enum logic [1:0] {
        SIE_RD_IDLE = 2'h1,
        SIE_RD_RESP = 2'h2
    } sie_rd_state_type;

endpackage

// ---- src/sie_baud_if.sv ----
interface sie_baud_if;
    logic [15:0] divisor;
    logic        tick;
    logic        sck;

    // Generator side and register side
    modport gen  (input divisor, output tick, output sck);
    modport user (output divisor, input tick, input sck);
endinterface

// ---- src/sie_wm_cmp.sv ----
module sie_wm_cmp
    import sie_pkg::*;
#(
    parameter bit AT_LEAST = 1'b1
) (
    input  wire logic       enable,
    input  wire logic       enhanced,
    input  wire logic [5:0] level,
    input  wire logic [5:0] count,
    output logic            match
);
    logic       level_ok;
    logic [5:0] lvl;

    // Absent level bits never take part in the compare
    assign lvl = level & SIE_LVL_IMPL;
    assign level_ok = ({26'h0, lvl} <= SIE_FIFO_DEPTH);

    // Counts only mean something in enhanced buffer mode
    // compare kind
    assign match = enable & enhanced & level_ok &
                   (AT_LEAST ? (lvl <= count) : (lvl == count));
endmodule

// ---- src/sie_baud_gen.sv ----
module sie_baud_gen
    import sie_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    sie_baud_if.gen    baud
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        sck_ff;
    logic        nxt_sck;
    logic        tick_ff;
    logic        nxt_tick;

    always_comb begin
        nxt_cnt  = cnt_ff + 16'h0001;
        nxt_sck  = sck_ff;
        nxt_tick = 1'b0;
        if (cnt_ff >= baud.divisor) begin
            nxt_cnt  = 16'h0000;
            nxt_sck  = ~sck_ff;
            nxt_tick = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff  <= 16'h0000;
            sck_ff  <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            sck_ff  <= nxt_sck;
            tick_ff <= nxt_tick;
        end
    end

    assign baud.sck  = sck_ff;
    assign baud.tick = tick_ff;
endmodule

// ---- src/sie_event_mask.sv ----
// What this block does
// - Activity enable set: busy flag raises an event; clear: never.
// - Underrun enable gates transmit underrun into an event.
// - Shift-empty enable gates shifter empty flag into an event.
// - Overflow enable gates receive overflow into an event.
// - Receive-empty enable gates receive buffer empty flag into an event.
// - Transmit-empty enable gates transmit buffer empty into an event.
// - Receive watermark fires when level is at most receive count.
// - Transmit watermark fires when level equals transmit count.
// - Levels above FIFO depth never produce a watermark match.
// - Level bits 2, 3, 4 exist only at depths 8, 16, 32.
// - Serial clock is bus clock over two times (divisor plus one).
// - Unimplemented enable and level bits read back zero.
// - Element counts are six bits, valid only in enhanced mode.
module sie_event_mask
    import sie_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic [2:0]   s_axi_awprot,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic [2:0]   s_axi_arprot,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic         frame_error_flag,
    input  wire logic         activity_flag,
    input  wire logic         underrun_flag,
    input  wire logic         shifter_empty_flag,
    input  wire logic         overflow_flag,
    input  wire logic         rx_empty_flag,
    input  wire logic         tx_empty_flag,
    input  wire logic         tx_full_flag,
    input  wire logic         rx_full_flag,
    input  wire logic         enhanced_buffer_mode,
    input  wire logic [5:0]   rx_element_count,
    input  wire logic [5:0]   tx_element_count,
    output logic              event_request,
    output logic              irq,
    output logic              sck_out,
    output logic              baud_tick
);
    // ****************************************
    // Declarations
    // ****************************************
    sie_wr_state_type wr_state_ff;
    sie_wr_state_type nxt_wr_state;
    sie_rd_state_type rd_state_ff;
    sie_rd_state_type nxt_rd_state;

    logic        aw_held_ff;
    logic        nxt_aw_held;
    logic        w_held_ff;
    logic        nxt_w_held;
    logic [7:0]  waddr_ff;
    logic [7:0]  nxt_waddr;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [3:0]  wstrb_ff;
    logic [3:0]  nxt_wstrb;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;

    logic [15:0] evt_en_ff;
    logic [15:0] nxt_evt_en;
    logic [15:0] wm_ff;
    logic [15:0] nxt_wm;
    logic [15:0] sts_ff;
    logic [15:0] nxt_sts;
    logic [15:0] mask_ff;
    logic [15:0] nxt_mask;
    logic [15:0] baud_div_ff;
    logic [15:0] nxt_baud_div;
    logic        evt_req_ff;
    logic        nxt_evt_req;
    logic        irq_ff;
    logic        nxt_irq;

    logic        do_write;
    logic [15:0] wr_bits;
    logic [15:0] wr_lanes;
    logic [15:0] flags;
    logic [15:0] events;
    logic        rx_wm_hit;
    logic        tx_wm_hit;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_hit;

    sie_baud_if baud_bus ();

    // ****************************************
    // Event qualification
    // ****************************************
    // Status flags gathered in the enable layout
    always_comb begin
        flags                = 16'h0000;
        flags[SIE_B_FRAME]   = frame_error_flag;
        flags[SIE_B_BUSY]    = activity_flag;
        flags[SIE_B_UNDR]    = underrun_flag;
        flags[SIE_B_SHMT]    = shifter_empty_flag;
        flags[SIE_B_OVF]     = overflow_flag;
        flags[SIE_B_RXE]     = rx_empty_flag;
        flags[SIE_B_TXE]     = tx_empty_flag;
        flags[SIE_B_TXF]     = tx_full_flag;
        flags[SIE_B_RXF]     = rx_full_flag;
    end

    always_comb begin
        events             = flags & evt_en_ff & SIE_EVT_IMPL;
        events[SIE_B_RXWM] = rx_wm_hit;
        events[SIE_B_TXWM] = tx_wm_hit;
    end

    sie_wm_cmp #(
        .AT_LEAST (1'b1)
    ) u_rx_cmp (
        .enable   (wm_ff[SIE_B_RX_WATERMARK_ENABLE]),
        .enhanced (enhanced_buffer_mode),
        .level    (wm_ff[SIE_RXLVL_LSB +: 6]),
        .count    (rx_element_count),
        .match    (rx_wm_hit)
    );

    sie_wm_cmp #(
        .AT_LEAST (1'b0)
    ) u_tx_cmp (
        .enable   (wm_ff[SIE_B_TX_WATERMARK_ENABLE]),
        .enhanced (enhanced_buffer_mode),
        .level    (wm_ff[SIE_TXLVL_LSB +: 6]),
        .count    (tx_element_count),
        .match    (tx_wm_hit)
    );

    // ****************************************
    // Serial clock divider
    // ****************************************
    // divisor feeds the generator
    assign baud_bus.divisor = baud_div_ff;

    sie_baud_gen u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .baud    (baud_bus.gen)
    );

    assign sck_out   = baud_bus.sck;
    assign baud_tick = baud_bus.tick;

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data may arrive in either order
    assign s_axi_awready = (wr_state_ff == SIE_WR_COLLECT) & ~aw_held_ff;
    assign s_axi_wready  = (wr_state_ff == SIE_WR_COLLECT) & ~w_held_ff;
    assign s_axi_bvalid  = (wr_state_ff == SIE_WR_RESP);
    assign s_axi_bresp   = bresp_ff;
    assign do_write      = (wr_state_ff == SIE_WR_COLLECT) &
                           aw_held_ff & w_held_ff;
    assign wr_lanes      = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_bits       = wdata_ff[15:0];

    // Write decode on the held address
    always_comb begin
        wr_hit = 1'b1;
        if (waddr_ff[7:2] == SIE_OFF_EVT_EN[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_WM[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_STS[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_IRQ_MASK[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_BAUD[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_FLAGS[7:2]) begin
            wr_hit = 1'b1;
        end else if (waddr_ff[7:2] == SIE_OFF_COUNTS[7:2]) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Write channel next state
    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_held  = aw_held_ff;
        nxt_w_held   = w_held_ff;
        nxt_waddr    = waddr_ff;
        nxt_wdata    = wdata_ff;
        nxt_wstrb    = wstrb_ff;
        nxt_bresp    = bresp_ff;
        case (wr_state_ff)
            SIE_WR_COLLECT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    nxt_aw_held = 1'b1;
                    nxt_waddr   = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    nxt_w_held = 1'b1;
                    nxt_wdata  = s_axi_wdata;
                    nxt_wstrb  = s_axi_wstrb;
                end
                if (do_write) begin
                    nxt_aw_held  = 1'b0;
                    nxt_w_held   = 1'b0;
                    nxt_bresp    = wr_hit ? SIE_RESP_OKAY
                                          : SIE_RESP_SLVERR;
                    nxt_wr_state = SIE_WR_RESP;
                end
            end
            SIE_WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_wr_state = SIE_WR_COLLECT;
                end
            end
            default: begin
                nxt_wr_state = SIE_WR_COLLECT;
            end
        endcase
    end

    // Write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= SIE_WR_COLLECT;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            waddr_ff    <= 8'h00;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            bresp_ff    <= SIE_RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff  <= nxt_aw_held;
            w_held_ff   <= nxt_w_held;
            waddr_ff    <= nxt_waddr;
            wdata_ff    <= nxt_wdata;
            wstrb_ff    <= nxt_wstrb;
            bresp_ff    <= nxt_bresp;
        end
    end

    // ****************************************
    // Register file and sticky status
    // ****************************************
    // Byte lanes honoured; absent bits never stored
    always_comb begin
        nxt_evt_en   = evt_en_ff;
        nxt_wm       = wm_ff;
        nxt_mask     = mask_ff;
        nxt_baud_div = baud_div_ff;
        nxt_sts      = sts_ff;
        if (do_write) begin
            if (waddr_ff[7:2] == SIE_OFF_EVT_EN[7:2]) begin
                nxt_evt_en = ((evt_en_ff & ~wr_lanes) |
                              (wr_bits & wr_lanes)) & SIE_EVT_IMPL;
            end else if (waddr_ff[7:2] == SIE_OFF_WM[7:2]) begin
                nxt_wm = ((wm_ff & ~wr_lanes) |
                          (wr_bits & wr_lanes)) & SIE_WM_IMPL;
            end else if (waddr_ff[7:2] == SIE_OFF_STS[7:2]) begin
                nxt_sts = sts_ff & ~(wr_bits & wr_lanes);
            end else if (waddr_ff[7:2] == SIE_OFF_IRQ_MASK[7:2]) begin
                nxt_mask = ((mask_ff & ~wr_lanes) |
                            (wr_bits & wr_lanes)) & SIE_STS_IMPL;
            end else if (waddr_ff[7:2] == SIE_OFF_BAUD[7:2]) begin
                nxt_baud_div = (baud_div_ff & ~wr_lanes) |
                               (wr_bits & wr_lanes);
            end
        end
        // Set after clear, so a fresh event is never lost
        nxt_sts = (nxt_sts | events) & SIE_STS_IMPL;
    end

    // request from enabled events, masked interrupt
    always_comb begin
        nxt_evt_req = |events;
        nxt_irq     = |(nxt_sts & mask_ff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_en_ff   <= SIE_RST_EVT_EN;
            wm_ff       <= SIE_RST_WM;
            sts_ff      <= 16'h0000;
            mask_ff     <= SIE_RST_MASK;
            baud_div_ff <= SIE_RST_BAUD;
            evt_req_ff  <= 1'b0;
            irq_ff      <= 1'b0;
        end else begin
            evt_en_ff   <= nxt_evt_en;
            wm_ff       <= nxt_wm;
            sts_ff      <= nxt_sts;
            mask_ff     <= nxt_mask;
            baud_div_ff <= nxt_baud_div;
            evt_req_ff  <= nxt_evt_req;
            irq_ff      <= nxt_irq;
        end
    end

    assign event_request = evt_req_ff;
    assign irq           = irq_ff;

    // ****************************************
    // Read channel
    // ****************************************
    // Read decode; unmapped words answer zero with an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr[7:2] == SIE_OFF_EVT_EN[7:2]) begin
            rd_word = {16'h0000, evt_en_ff};
        end else if (s_axi_araddr[7:2] == SIE_OFF_WM[7:2]) begin
            rd_word = {16'h0000, wm_ff};
        end else if (s_axi_araddr[7:2] == SIE_OFF_STS[7:2]) begin
            rd_word = {16'h0000, sts_ff};
        end else if (s_axi_araddr[7:2] == SIE_OFF_IRQ_MASK[7:2]) begin
            rd_word = {16'h0000, mask_ff};
        end else if (s_axi_araddr[7:2] == SIE_OFF_BAUD[7:2]) begin
            rd_word = {16'h0000, baud_div_ff};
        end else if (s_axi_araddr[7:2] == SIE_OFF_FLAGS[7:2]) begin
            rd_word = {16'h0000, flags};
        end else if (s_axi_araddr[7:2] == SIE_OFF_COUNTS[7:2]) begin
            rd_word = {18'h00000, rx_element_count,
                       2'h0, tx_element_count};
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign s_axi_arready = (rd_state_ff == SIE_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_ff == SIE_RD_RESP);
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Read channel next state
    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_rdata    = rdata_ff;
        nxt_rresp    = rresp_ff;
        case (rd_state_ff)
            SIE_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_rdata    = rd_word;
                    nxt_rresp    = rd_hit ? SIE_RESP_OKAY
                                          : SIE_RESP_SLVERR;
                    nxt_rd_state = SIE_RD_RESP;
                end
            end
            SIE_RD_RESP: begin
                if (s_axi_rready) begin
                    nxt_rd_state = SIE_RD_IDLE;
                end
            end
            default: begin
                nxt_rd_state = SIE_RD_IDLE;
            end
        endcase
    end

    // Read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= SIE_RD_IDLE;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= SIE_RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
        end
    end

endmodule

// ---- testbench/sie_status_model.sv ----
module sie_status_model (
    input  wire logic       aclk,
    input  wire logic [8:0] want,
    output logic      [8:0] flags
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels move just after an edge, like the real status source
    always @(posedge aclk) begin
        flags <= want;
    end
endmodule

// ---- testbench/sie_event_mask_assertions.sv ----
module sie_event_mask_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_out,
    input wire logic baud_tick
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****
    // Register bus
    // ****
    chk_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer");
    chk_wr_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_wr_reopen: assert property (
        $fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
        else $error("write not reopened");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer");
    chk_rd_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_rd_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released");
    // ****
    // Serial clock
    // ****
    chk_tick_toggle: assert property (
        baud_tick |-> sck_out != $past(sck_out)) else $error("no toggle");
    chk_sck_steady: assert property (
        !baud_tick |-> $stable(sck_out)) else $error("stray toggle");
endmodule

bind sie_event_mask sie_event_mask_checker i_sie_event_mask_checker (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .sck_out, .baud_tick
);

// ---- testbench/sie_event_mask_tb_top.sv ----
module sie_event_mask_tb_top import sie_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 0, aresetn = 0, enhanced_buffer_mode = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, event_request, irq, sck_out, baud_tick;
    logic [5:0]  rx_element_count = 0, tx_element_count = 0;
    logic [8:0]  want = 0, flags;
    wire         frame_error_flag, activity_flag, underrun_flag;
    wire         shifter_empty_flag, overflow_flag, rx_empty_flag;
    wire         tx_empty_flag, tx_full_flag, rx_full_flag;
    int          errors = 0, compares = 0, cycles = 0;
    assign {frame_error_flag, activity_flag, underrun_flag,
            shifter_empty_flag, overflow_flag, rx_empty_flag,
            tx_empty_flag, tx_full_flag, rx_full_flag} = flags;
    always #20 aclk = ~aclk;
    sie_status_model i_sie_status_model (.aclk, .want, .flags);
    sie_event_mask i_sie_event_mask (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .frame_error_flag, .activity_flag,
        .underrun_flag, .shifter_empty_flag, .overflow_flag, .rx_empty_flag,
        .tx_empty_flag, .tx_full_flag, .rx_full_flag, .enhanced_buffer_mode,
        .rx_element_count, .tx_element_count, .event_request, .irq,
        .sck_out, .baud_tick);
    // ****
    // Bus tasks and compare
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 0;
        bit w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, a > 8'h1B ? SIE_RESP_SLVERR : SIE_RESP_OKAY);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk(s_axi_rresp, a > 8'h1B ? SIE_RESP_SLVERR : SIE_RESP_OKAY);
        s_axi_rready <= 0;
    endtask
    task automatic close_out;
        $display("Compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            close_out();
        end
    end
    // ****
    // Tests
    // ****
    initial begin
        logic [31:0] d;
        int n;
        int pos [9] = '{0, 1, 3, 5, 6, 7, 8, 11, 12};
        int lv [6] = '{5, 6, 0, 33, 32, 5};
        int cn [6] = '{5, 5, 0, 33, 32, 5};
        bit en [6] = '{1, 1, 1, 1, 1, 0};
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        for (int a = 0; a < 5; a++) begin
            rd(8'(a * 4), d);
            chk(d, 0);
        end
        wr(SIE_OFF_EVT_EN, 32'hFFFFFFFF);
        rd(SIE_OFF_EVT_EN, d);
        chk(d, 32'h000019EB);
        wr(SIE_OFF_WM, 32'hFFFFFFFF);
        rd(SIE_OFF_WM, d);
        chk(d, 32'h0000BFBF);
        wr(8'h40, 32'h1);
        rd(8'h40, d);
        chk(d, 0);
        wr(SIE_OFF_WM, 0);
        $display("Test registers done");
        // Each flag gated by its own enable, sticky status, irq mask
        for (int i = 0; i < 9; i++) begin
            wr(SIE_OFF_EVT_EN, 0);
            want <= 9'(1 << i);
            repeat (3) @(posedge aclk);
            chk(event_request, 0);
            wr(SIE_OFF_EVT_EN, 32'(1 << pos[i]));
            repeat (2) @(posedge aclk);
            chk(event_request, 1);
            rd(SIE_OFF_STS, d);
            chk(d, 32'(1 << pos[i]));
            rd(SIE_OFF_FLAGS, d);
            chk(d, 32'(1 << pos[i]));
            chk(irq, 0);
            wr(SIE_OFF_IRQ_MASK, 32'(1 << pos[i]));
            repeat (2) @(posedge aclk);
            chk(irq, 1);
            want <= 0;
            // Model edge, then design edge, then one more to see the level
            repeat (3) @(posedge aclk);
            chk(event_request, 0);
            chk(irq, 1);
            wr(SIE_OFF_STS, 32'(1 << pos[i]));
            rd(SIE_OFF_STS, d);
            chk(d, 0);
            chk(irq, 0);
            wr(SIE_OFF_IRQ_MASK, 0);
        end
        wr(SIE_OFF_EVT_EN, 0);
        $display("Test events done");
        // Receive side is at-least, transmit side is exact match
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 6; k++) begin
                enhanced_buffer_mode <= en[k];
                rx_element_count <= 6'(cn[k]);
                tx_element_count <= 6'(cn[k]);
                d = s ? 32'h80 | lv[k] : 32'h8000 | (lv[k] << 8);
                wr(SIE_OFF_WM, d);
                repeat (2) @(posedge aclk);
                chk(event_request, en[k] && lv[k] <= 32
                    && (s ? lv[k] == cn[k] : lv[k] <= cn[k]));
                rd(SIE_OFF_COUNTS, d);
                chk(d, 32'((cn[k] << 8) | cn[k]));
            end
        end
        wr(SIE_OFF_WM, 0);
        $display("Test watermarks done");
        // Toggle spacing is divisor plus one cycles
        for (int k = 0; k < 2; k++) begin
            wr(SIE_OFF_BAUD, 32'(k * 3));
            repeat (2) begin
                @(posedge aclk);
                while (!baud_tick) @(posedge aclk);
            end
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (!baud_tick);
            chk(32'(n), 32'(k * 3 + 1));
        end
        $display("Test baud done");
        close_out();
    end
endmodule
